// file: power_stage_gate_control_tb.sv
// Self-checking testbench for the power stage gate control block
`timescale 1ns/1ps

module power_stage_gate_control_tb;

	logic                   clk;
	logic                   rstn;
	logic                   dn;
	logic                   dn_float;
	logic                   zx;
	logic                   hs;
	logic                   oc;
	pscg_pkg::pscg_region_t pwm_m;
	pscg_pkg::pscg_region_t zc_m;
	logic                   pwm_hi;
	logic                   pwm_lo;
	tri1                    dis_pin;
	logic                   hg;
	logic                   lg;
	logic                   flt;
	logic                   sense;
	logic                   stby;
	logic                   deep;
	pscg_pkg::pscg_gate_t   g_seen;
	int                     n_mismatch;
	int                     cmp_count;

	// Released disable pin is pulled up by the net itself
	assign dis_pin = dn_float ? 1'bz : dn;
	assign g_seen  = {hg, lg};

	////////////////////////////////////////////////////////////////////////
	pscg_ctrl_model u_ctrl (
		.i_clk   (clk),
		.i_mode  (pwm_m),
		.o_above (pwm_hi),
		.o_below (pwm_lo)
	);

	pscg_gate_ctrl dut_u (
		.I_SYS_CLK            (clk),
		.I_RSTN               (rstn),
		.I_DISABLE_N_INPUT    (dis_pin),
		.I_PWM_ABOVE          (pwm_hi),
		.I_PWM_BELOW          (pwm_lo),
		.I_ZCEN_ABOVE         (zc_m == pscg_pkg::RG_HIGH),
		.I_ZCEN_BELOW         (zc_m == pscg_pkg::RG_LOW),
		.I_ZERO_CROSS         (zx),
		.I_HS_SHORT           (hs),
		.I_OVER_CURRENT       (oc),
		.O_HIGH_GATE_CMD      (hg),
		.O_LOW_GATE_CMD       (lg),
		.O_TEMP_FAULT_OUTPUT  (flt),
		.O_SENSE_NET_EN       (sense),
		.O_STANDBY            (stby),
		.O_DEEP_STANDBY_STATE (deep)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [1:0] seen, logic [1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %b seen %b", name, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Expected gate pair from the decoded inputs, highest priority first
	function automatic pscg_pkg::pscg_gate_t exp_gates(logic d,
		pscg_pkg::pscg_region_t zc, pscg_pkg::pscg_region_t pw,
		logic zs, logic sh);
		if (!d) return 2'b00;
		if (sh) return 2'b01;
		if (zc == pscg_pkg::RG_TRI) return 2'b00;
		if (pw == pscg_pkg::RG_TRI) return 2'b00;
		if (pw == pscg_pkg::RG_HIGH) return 2'b10;
		if (zc == pscg_pkg::RG_HIGH) return 2'b01;
		if (zs) return 2'b00;
		return 2'b01;
	endfunction

	function automatic pscg_pkg::pscg_region_t pick();
		case ($urandom % 3)
			0: return pscg_pkg::RG_LOW;
			1: return pscg_pkg::RG_TRI;
			default: return pscg_pkg::RG_HIGH;
		endcase
	endfunction

	// Bounded wait for the gate pair to settle, then compare
	task automatic wait_gate(pscg_pkg::pscg_gate_t e);
		int k;
		k = 0;
		tick(8);
		while (g_seen !== e && k < 12) begin
			tick(1);
			k++;
		end
		check("gates", g_seen, e);
		// A wait that used up its bound ends the run
		if (g_seen !== e)
			give_verdict();
	endtask

	task automatic chk_all(logic d, pscg_pkg::pscg_region_t zc,
		pscg_pkg::pscg_region_t pw, logic zs, logic sh);
		logic dp;
		dp = d && zc == pscg_pkg::RG_TRI && pw == pscg_pkg::RG_TRI;
		wait_gate(exp_gates(d, zc, pw, zs, sh));
		check("standby", {1'b0, stby}, {1'b0, !d});
		check("sense", {1'b0, sense}, {1'b0, d});
		check("deep", {1'b0, deep}, {1'b0, dp});
	endtask

	task automatic pwm_cycles(int n);
		repeat (n) begin
			pwm_m = pscg_pkg::RG_HIGH;
			tick(4);
			pwm_m = pscg_pkg::RG_LOW;
			tick(4);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Both gates must never be on together
	always @(negedge clk) begin
		if (rstn === 1'b1)
			check("overlap", {1'b0, hg & lg}, 2'b00);
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		dn = 1'b1;
		dn_float = 1'b0;
		zx = 1'b0;
		hs = 1'b0;
		oc = 1'b0;
		pwm_m = pscg_pkg::RG_TRI;
		zc_m = pscg_pkg::RG_TRI;
		n_mismatch = 0;
		cmp_count = 0;
		void'($urandom(89));
		tick(12);
		rstn = 1'b1;
		chk_all(1, zc_m, pwm_m, 0, 0);
		// Floating disable pin leaves the stage enabled
		dn_float = 1'b1;
		dn = 1'b0;
		zc_m = pscg_pkg::RG_HIGH;
		pwm_m = pscg_pkg::RG_LOW;
		chk_all(1, zc_m, pwm_m, 0, 0);
		dn_float = 1'b0;
		repeat (40) begin
			dn = ($urandom % 4) != 0;
			zc_m = pick();
			pwm_m = pick();
			chk_all(dn, zc_m, pwm_m, 0, 0);
		end
		// Diode emulation: zero crossing ends the low phase
		dn = 1'b1;
		zc_m = pscg_pkg::RG_LOW;
		pwm_m = pscg_pkg::RG_HIGH;
		chk_all(1, zc_m, pwm_m, 0, 0);
		pwm_m = pscg_pkg::RG_LOW;
		chk_all(1, zc_m, pwm_m, 0, 0);
		zx = 1'b1;
		chk_all(1, zc_m, pwm_m, 1, 0);
		zx = 1'b0;
		zc_m = pscg_pkg::RG_HIGH;
		chk_all(1, zc_m, pwm_m, 1, 0);
		zx = 1'b1;
		chk_all(1, zc_m, pwm_m, 1, 0);
		zx = 1'b0;
		// One-cycle tri-state glitch must not disturb the gates
		pwm_m = pscg_pkg::RG_HIGH;
		chk_all(1, zc_m, pwm_m, 0, 0);
		pwm_m = pscg_pkg::RG_TRI;
		tick(1);
		pwm_m = pscg_pkg::RG_HIGH;
		repeat (10) begin
			tick(1);
			check("gates", g_seen, 2'b10);
		end
		// Over-current flag clears after enough clean cycles
		oc = 1'b1;
		tick(3);
		oc = 1'b0;
		tick(6);
		check("fault", {1'b0, flt}, 2'b01);
		// PWM already high: n calls give n-1 high entries
		pwm_cycles(128);
		check("fault", {1'b0, flt}, 2'b01);
		pwm_cycles(1);
		tick(4);
		check("fault", {1'b0, flt}, 2'b00);
		// Repeated high-side short latches until reset
		hs = 1'b1;
		pwm_cycles(3);
		check("fault", {1'b0, flt}, 2'b00);
		pwm_cycles(3);
		pwm_m = pscg_pkg::RG_HIGH;
		tick(10);
		check("fault", {1'b0, flt}, 2'b01);
		check("gates", g_seen, 2'b01);
		hs = 1'b0;
		pwm_cycles(2);
		chk_all(1, zc_m, pwm_m, 0, 1);
		check("fault", {1'b0, flt}, 2'b01);
		rstn = 1'b0;
		tick(3);
		rstn = 1'b1;
		chk_all(1, zc_m, pwm_m, 0, 0);
		check("fault", {1'b0, flt}, 2'b00);
		give_verdict();
	end

endmodule // power_stage_gate_control_tb

// file: pscg_ctrl_model.sv
// Controller-side model that drives the PWM pin as seen by its comparators
`timescale 1ns/1ps

module pscg_ctrl_model (
	input  wire logic                   i_clk,
	input  wire pscg_pkg::pscg_region_t i_mode,
	output logic                        o_above,
	output logic                        o_below
);

	////////////////////////////////////////////////////////////////////////
	// Output changes just after an edge; released pin trips neither side
	always_ff @(posedge i_clk) begin
		o_above <= (i_mode == pscg_pkg::RG_HIGH);
		o_below <= (i_mode == pscg_pkg::RG_LOW);
	end

endmodule // pscg_ctrl_model

// file: pscg_gate_ctrl.sv
// Gate command sequencer with three-level input decoders
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Three-level input decoder: synchroniser plus persistence hysteresis
module pscg_region #(
	parameter int FILT = pscg_pkg::REGION_FILT_CYC
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_above,
	input  wire logic                  i_below,
	output pscg_pkg::pscg_region_t     o_region
);
	logic                    above_s1_r;
	logic                    above_s2_r;
	logic                    below_s1_r;
	logic                    below_s2_r;
	logic [7:0]              filt_cnt_r;
	pscg_pkg::pscg_region_t  region_r;
	pscg_pkg::pscg_region_t  raw;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			above_s1_r <= 1'b0;
			above_s2_r <= 1'b0;
			below_s1_r <= 1'b0;
			below_s2_r <= 1'b0;
		end else begin
			above_s1_r <= i_above;
			above_s2_r <= above_s1_r;
			below_s1_r <= i_below;
			below_s2_r <= below_s1_r;
		end
	end

	always_comb begin
		if (above_s2_r)
			raw = pscg_pkg::RG_HIGH;
		else if (below_s2_r)
			raw = pscg_pkg::RG_LOW;
		else
			raw = pscg_pkg::RG_TRI;
	end

	// New region must persist before it replaces the old one
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			region_r   <= pscg_pkg::RG_TRI;
			filt_cnt_r <= 8'h00;
		end else if (raw == region_r) begin
			filt_cnt_r <= 8'h00;
		end else if (filt_cnt_r >= 8'(FILT - 1)) begin
			region_r   <= raw;
			filt_cnt_r <= 8'h00;
		end else begin
			filt_cnt_r <= filt_cnt_r + 8'h01;
		end
	end

	assign o_region = region_r;
endmodule // pscg_region

////////////////////////////////////////////////////////////////////////////////
// Function
// - Disable low: both gates off, standby
// - Disable low: disconnect PWM and disable sensing
// - Unconnected disable reads as enabled
// - PWM high: low gate off, then high on
// - PWM low: high gate off, then low on
// - Decode PWM as high, low or tri-state
// - Tri-state for hold-off time: both gates off
// - Region decoding uses hysteresis against noise
// - Zero-cross enable low allows diode emulation
// - Zero-cross enable high forces continuous conduction
// - Zero crossing turns low gate off
// - Zero-cross enable changes apply immediately
// - Floating zero-cross enable decodes as tri-state
// - Both inputs tri-state: enter deep standby
// - Zero-cross enable tri-state: both gates off
// - Four high-side short cycles: latched fault, low on
// - Over-current fault clears after 128 clean cycles
module pscg_gate_ctrl (
	input  wire logic I_SYS_CLK,
	input  wire logic I_RSTN,
	input  wire logic I_DISABLE_N_INPUT,
	input  wire logic I_PWM_ABOVE,
	input  wire logic I_PWM_BELOW,
	input  wire logic I_ZCEN_ABOVE,
	input  wire logic I_ZCEN_BELOW,
	input  wire logic I_ZERO_CROSS,
	input  wire logic I_HS_SHORT,
	input  wire logic I_OVER_CURRENT,
	output logic      O_HIGH_GATE_CMD,
	output logic      O_LOW_GATE_CMD,
	output logic      O_TEMP_FAULT_OUTPUT,
	output logic      O_SENSE_NET_EN,
	output logic      O_STANDBY,
	output logic      O_DEEP_STANDBY_STATE
);
	localparam int HOLDOFF = pscg_pkg::HOLDOFF_CYC;
	localparam int DEAD    = pscg_pkg::DEAD_CYC;

	logic                                dis_s1_r;
	logic                                dis_s2_r;
	logic [2:0]                          evt_s1_r;
	logic [2:0]                          evt_s2_r;
	logic                                zc_s;
	logic                                hs_s;
	logic                                oc_s;
	pscg_pkg::pscg_region_t              pwm_reg;
	pscg_pkg::pscg_region_t              zcd_reg;
	logic [pscg_pkg::TRI_CNT_W-1:0]      tri_cnt_r;
	logic                                tri_expired;
	pscg_pkg::pscg_target_t              target_r;
	pscg_pkg::pscg_target_t              target_nxt;
	logic                                zc_off_r;
	pscg_pkg::pscg_state_t               state_r;
	pscg_pkg::pscg_state_t               state_nxt;
	logic [pscg_pkg::DEAD_CNT_W-1:0]     dead_cnt_r;
	pscg_pkg::pscg_gate_t                gate_r;
	logic                                pwm_prev_hi_r;
	logic                                cycle_pulse;
	logic                                hs_seen_r;
	logic [pscg_pkg::HS_CNT_W-1:0]       hs_cnt_r;
	logic                                hs_latch_r;
	logic                                oc_flag_r;
	logic [pscg_pkg::OC_CNT_W-1:0]       oc_clean_r;
	logic                                fault_r;
	logic                                sense_en_r;
	logic                                standby_r;
	logic                                deep_r;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; disable starts deasserted as if pulled up
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			dis_s1_r <= pscg_pkg::DISABLE_N_RST;
			dis_s2_r <= pscg_pkg::DISABLE_N_RST;
		end else begin
			dis_s1_r <= I_DISABLE_N_INPUT;
			dis_s2_r <= dis_s1_r;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			evt_s1_r <= 3'h0;
			evt_s2_r <= 3'h0;
		end else begin
			evt_s1_r <= {I_OVER_CURRENT, I_HS_SHORT, I_ZERO_CROSS};
			evt_s2_r <= evt_s1_r;
		end
	end

	assign zc_s = evt_s2_r[0];
	assign hs_s = evt_s2_r[1];
	assign oc_s = evt_s2_r[2];

	// PWM and zero-cross enable decoders; both rest at tri-state
	pscg_region u_pwm_region (
		.i_clk    (I_SYS_CLK),
		.i_rstn   (I_RSTN),
		.i_above  (I_PWM_ABOVE),
		.i_below  (I_PWM_BELOW),
		.o_region (pwm_reg)
	);

	pscg_region u_zcd_region (
		.i_clk    (I_SYS_CLK),
		.i_rstn   (I_RSTN),
		.i_above  (I_ZCEN_ABOVE),
		.i_below  (I_ZCEN_BELOW),
		.o_region (zcd_reg)
	);

	////////////////////////////////////////////////////////////////////////
	// Tri-state hold-off timer, restarted whenever PWM leaves tri-state
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			tri_cnt_r <= '0;
		else if (pwm_reg != pscg_pkg::RG_TRI)
			tri_cnt_r <= '0;
		else if (tri_cnt_r < pscg_pkg::TRI_CNT_W'(HOLDOFF))
			tri_cnt_r <= tri_cnt_r + 1'b1;
	end

	assign tri_expired = (tri_cnt_r >= pscg_pkg::TRI_CNT_W'(HOLDOFF));

	// Zero crossing seen in this low phase; cleared by next high
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			zc_off_r <= 1'b0;
		else if (zc_s && state_r == pscg_pkg::ST_LOW)
			zc_off_r <= 1'b1;
		else if (pwm_reg == pscg_pkg::RG_HIGH)
			zc_off_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Target selection, in priority order
	always_comb begin
		target_nxt = target_r;
		if (!dis_s2_r)
			target_nxt = pscg_pkg::TG_OFF;
		else if (hs_latch_r)
			target_nxt = pscg_pkg::TG_LOW;
		else if (zcd_reg == pscg_pkg::RG_TRI)
			target_nxt = pscg_pkg::TG_OFF;
		else if (pwm_reg == pscg_pkg::RG_TRI)
			target_nxt = tri_expired ? pscg_pkg::TG_OFF : target_r;
		else if (pwm_reg == pscg_pkg::RG_HIGH)
			target_nxt = pscg_pkg::TG_HIGH;
		else if (zcd_reg == pscg_pkg::RG_HIGH)
			target_nxt = pscg_pkg::TG_LOW;
		else if (zc_off_r || zc_s)
			target_nxt = pscg_pkg::TG_OFF;
		else
			target_nxt = pscg_pkg::TG_LOW;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			target_r <= pscg_pkg::TG_OFF;
		else
			target_r <= target_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Gate sequencer: every turn-on passes through a dead state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
		pscg_pkg::ST_OFF, pscg_pkg::ST_HIGH, pscg_pkg::ST_LOW: begin
			if (target_nxt == pscg_pkg::TG_OFF)
				state_nxt = pscg_pkg::ST_OFF;
			else if (target_nxt == pscg_pkg::TG_HIGH &&
					state_r != pscg_pkg::ST_HIGH)
				state_nxt = pscg_pkg::ST_DEAD_H;
			else if (target_nxt == pscg_pkg::TG_LOW &&
					state_r != pscg_pkg::ST_LOW)
				state_nxt = pscg_pkg::ST_DEAD_L;
		end
		pscg_pkg::ST_DEAD_H: begin
			if (target_nxt == pscg_pkg::TG_OFF)
				state_nxt = pscg_pkg::ST_OFF;
			else if (target_nxt == pscg_pkg::TG_LOW)
				state_nxt = pscg_pkg::ST_DEAD_L;
			else if (dead_cnt_r >= pscg_pkg::DEAD_CNT_W'(DEAD - 1))
				state_nxt = pscg_pkg::ST_HIGH;
		end
		pscg_pkg::ST_DEAD_L: begin
			if (target_nxt == pscg_pkg::TG_OFF)
				state_nxt = pscg_pkg::ST_OFF;
			else if (target_nxt == pscg_pkg::TG_HIGH)
				state_nxt = pscg_pkg::ST_DEAD_H;
			else if (dead_cnt_r >= pscg_pkg::DEAD_CNT_W'(DEAD - 1))
				state_nxt = pscg_pkg::ST_LOW;
		end
		default: state_nxt = pscg_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			state_r    <= pscg_pkg::ST_OFF;
			dead_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				dead_cnt_r <= '0;
			else
				dead_cnt_r <= dead_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			gate_r <= '0;
		end else begin
			gate_r.high_gate_cmd <= (state_nxt == pscg_pkg::ST_HIGH);
			gate_r.low_gate_cmd  <= (state_nxt == pscg_pkg::ST_LOW);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Switching cycles are counted at each PWM high entry
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			pwm_prev_hi_r <= 1'b0;
		else
			pwm_prev_hi_r <= (pwm_reg == pscg_pkg::RG_HIGH);
	end

	assign cycle_pulse = (pwm_reg == pscg_pkg::RG_HIGH) && !pwm_prev_hi_r;

	// High-side short: consecutive cycles, latched until reset
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			hs_seen_r  <= 1'b0;
			hs_cnt_r   <= '0;
			hs_latch_r <= 1'b0;
		end else if (cycle_pulse) begin
			hs_seen_r <= hs_s;
			if (!(hs_seen_r || hs_s))
				hs_cnt_r <= '0;
			else if (hs_cnt_r >=
					pscg_pkg::HS_CNT_W'(pscg_pkg::HS_SHORT_CYCLES - 1))
				hs_latch_r <= 1'b1;
			else
				hs_cnt_r <= hs_cnt_r + 1'b1;
		end else if (hs_s) begin
			hs_seen_r <= 1'b1;
		end
	end

	// Over-current flag; a new event wins over the clean-cycle clear
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			oc_flag_r  <= 1'b0;
			oc_clean_r <= '0;
		end else if (oc_s) begin
			oc_flag_r  <= 1'b1;
			oc_clean_r <= '0;
		end else if (cycle_pulse && oc_flag_r) begin
			if (oc_clean_r >=
					pscg_pkg::OC_CNT_W'(pscg_pkg::OC_CLEAN_CYCLES - 1)) begin
				oc_flag_r  <= 1'b0;
				oc_clean_r <= '0;
			end else begin
				oc_clean_r <= oc_clean_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			fault_r    <= 1'b0;
			sense_en_r <= 1'b0;
			standby_r  <= 1'b0;
			deep_r     <= 1'b0;
		end else begin
			fault_r    <= hs_latch_r || oc_flag_r;
			sense_en_r <= dis_s2_r;
			standby_r  <= !dis_s2_r;
			deep_r     <= dis_s2_r && pwm_reg == pscg_pkg::RG_TRI &&
				zcd_reg == pscg_pkg::RG_TRI;
		end
	end

	assign O_HIGH_GATE_CMD      = gate_r.high_gate_cmd;
	assign O_LOW_GATE_CMD       = gate_r.low_gate_cmd;
	assign O_TEMP_FAULT_OUTPUT  = fault_r;
	assign O_SENSE_NET_EN       = sense_en_r;
	assign O_STANDBY            = standby_r;
	assign O_DEEP_STANDBY_STATE = deep_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RSTN);

	no_overlap_a: assert property (
		!(O_HIGH_GATE_CMD && O_LOW_GATE_CMD))
		else $error("both gate commands on");

	disable_off_a: assert property (
		!dis_s2_r |=> !O_HIGH_GATE_CMD && !O_LOW_GATE_CMD && O_STANDBY)
		else $error("gates not off while disabled");

	sense_off_a: assert property (
		!dis_s2_r |=> !O_SENSE_NET_EN)
		else $error("sensing still connected while disabled");

	pwm_high_a: assert property (
		(dis_s2_r && !hs_latch_r && zcd_reg != pscg_pkg::RG_TRI &&
		pwm_reg == pscg_pkg::RG_HIGH)[*4] |-> O_HIGH_GATE_CMD)
		else $error("high gate not on for steady PWM high");

	pwm_low_a: assert property (
		(dis_s2_r && !hs_latch_r && zcd_reg == pscg_pkg::RG_HIGH &&
		pwm_reg == pscg_pkg::RG_LOW)[*4] |-> O_LOW_GATE_CMD)
		else $error("low gate not on for steady PWM low");

	tri_holdoff_a: assert property (
		(dis_s2_r && !hs_latch_r && pwm_reg == pscg_pkg::RG_TRI)[*3]
		|=> !O_HIGH_GATE_CMD && !O_LOW_GATE_CMD)
		else $error("gates on after tri-state hold-off");

	holdoff_restart_a: assert property (
		pwm_reg != pscg_pkg::RG_TRI |=> tri_cnt_r == '0)
		else $error("hold-off timer not restarted");

	zcd_tri_off_a: assert property (
		(dis_s2_r && !hs_latch_r && zcd_reg == pscg_pkg::RG_TRI)[*2]
		|-> !O_HIGH_GATE_CMD && !O_LOW_GATE_CMD)
		else $error("gates on with zero-cross enable tri-state");

	deep_standby_a: assert property (
		dis_s2_r && pwm_reg == pscg_pkg::RG_TRI &&
		zcd_reg == pscg_pkg::RG_TRI |=> O_DEEP_STANDBY_STATE)
		else $error("deep standby not entered");

	zero_cross_a: assert property (
		(dis_s2_r && !hs_latch_r && zc_off_r &&
		zcd_reg == pscg_pkg::RG_LOW && pwm_reg == pscg_pkg::RG_LOW)[*2]
		|-> !O_LOW_GATE_CMD)
		else $error("low gate on after zero crossing");

	hs_fault_a: assert property (
		(hs_latch_r && dis_s2_r)[*3] |-> O_TEMP_FAULT_OUTPUT &&
		!O_HIGH_GATE_CMD && O_LOW_GATE_CMD)
		else $error("short fault not acted on");

	oc_fault_a: assert property (
		oc_s |-> ##2 O_TEMP_FAULT_OUTPUT)
		else $error("over-current fault not reported");

endmodule // pscg_gate_ctrl

// file: pscg_pkg.sv
// Shared constants and types for the power stage gate control block
package pscg_pkg;

	// Clock and timing figures
	localparam int CLK_PERIOD_NS    = 50;
	localparam int HOLDOFF_TIME_NS  = 30;
	localparam int DEAD_TIME_NS     = 30;

	// Least times round up, never below one cycle
	localparam int HOLDOFF_CYC_RAW  =
		(HOLDOFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLDOFF_CYC      = (HOLDOFF_CYC_RAW < 1) ? 1 :
		HOLDOFF_CYC_RAW;
	localparam int DEAD_CYC_RAW     =
		(DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_CYC         = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;

	// Switching cycle counts for protection
	localparam int HS_SHORT_CYCLES  = 4;
	localparam int OC_CLEAN_CYCLES  = 128;

	// Cycles a new input region must persist before it is accepted
	localparam int REGION_FILT_CYC  = 2;

	// Counter widths
	localparam int TRI_CNT_W        = 8;
	localparam int DEAD_CNT_W       = 8;
	localparam int HS_CNT_W         = 3;
	localparam int OC_CNT_W         = 8;

	// Reset value of the disable input synchroniser: enabled by default
	localparam logic DISABLE_N_RST  = 1'b1;

	// Decoded level of a three-level input
	typedef enum logic [1:0] {
		RG_LOW  = 2'b00,
		RG_TRI  = 2'b01,
		RG_HIGH = 2'b11
	} pscg_region_t;

	// What the gate sequencer is steering toward
	typedef enum logic [1:0] {
		TG_OFF  = 2'b00,
		TG_HIGH = 2'b01,
		TG_LOW  = 2'b11
	} pscg_target_t;

	// Gate sequencer states, Gray along off, dead, on, dead, on
	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,
		ST_DEAD_H = 3'b001,
		ST_HIGH   = 3'b011,
		ST_DEAD_L = 3'b010,
		ST_LOW    = 3'b110
	} pscg_state_t;

	// Pair of gate commands
	typedef struct packed {
		logic high_gate_cmd;
		logic low_gate_cmd;
	} pscg_gate_t;

endpackage
